// ===== src/limiter_pkg.sv
// constants and types for the overload current limiter
package limiter_pkg;
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] SET1_OFS = 5'h04;
    localparam logic [4:0] SET2_OFS = 5'h08;
    localparam logic [4:0] OUT_FUNC_OFS = 5'h0c;
    localparam logic [4:0] STATUS_OFS = 5'h10;
    localparam logic [4:0] MASK_OFS = 5'h14;
    localparam logic [4:0] STATE_OFS = 5'h18;
    localparam logic [4:0] IN_FUNC_OFS = 5'h1c;
    localparam int MODE_LSB = 0;
    localparam int LEVEL_LSB = 8;
    localparam int RATE_LSB = 16;
    localparam int WARN_LSB = 8;
    localparam logic [7:0] LEVEL_MIN = 8'h14;
    localparam logic [7:0] LEVEL_MAX = 8'hc8;
    localparam logic [7:0] LEVEL_RST = 8'h96;
    localparam logic [14:0] RATE_MIN = 15'h0001;
    localparam logic [14:0] RATE_MAX = 15'h7530;
    localparam logic [14:0] RATE_RST = 15'h000a;
    localparam logic [7:0] SUPPRESS_PCT = 8'hb4;
    localparam logic [7:0] WARN_RST = 8'h50;
    localparam logic [7:0] THM_FUNC = 8'h0d;
    localparam logic [7:0] SET_SELECT_FUNC = 8'h27;
    localparam int IN_TERMS = 4;
    localparam int CLK_NS = 50;
    localparam int TENTH_SEC_NS = 100000000;
    localparam int TENTH_SEC_CYCLES = TENTH_SEC_NS / CLK_NS;
    localparam int FULL_SCALE_STEPS = 1000;
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_ACC_CONST,
        MODE_CONST_ONLY,
        MODE_ACC_REGEN
    } restrict_mode_type;
    localparam restrict_mode_type MODE_RST = MODE_ACC_CONST;
    typedef enum logic {R_IDLE, R_ACTIVE} restrict_state_type;
endpackage : limiter_pkg

// ===== src/overload_current_limiter.sv
// overload restriction, trip suppression and thermal warning
`timescale 1ns/100ps
module overload_current_limiter
    import limiter_pkg::*;
#(
    parameter int TENTH_CYCLES = TENTH_SEC_CYCLES,
    parameter int FULL_STEPS = FULL_SCALE_STEPS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] current_pct,
    input wire logic [7:0] thermal_pct,
    input wire logic ramp_accel,
    input wire logic ramp_decel,
    input wire logic ramp_const,
    input wire logic regen,
    input wire logic [IN_TERMS-1:0] in_terms,
    output logic freq_down_step,
    output logic freq_up_step,
    output logic ramp_hold,
    output logic out_term1,
    output logic out_term2,
    output logic relay_out,
    output logic irq
);
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // out-of-range settings are pulled to the nearest limit, not refused
    function automatic logic [31:0] set_word(input logic [31:0] w);
        logic [31:0] r;
        logic [15:0] lvl;
        logic [15:0] rt;
        r = '0;
        r[MODE_LSB +: 2] = w[MODE_LSB +: 2];
        lvl = clamp({8'h00, w[LEVEL_LSB +: 8]}, {8'h00, LEVEL_MIN}, {8'h00, LEVEL_MAX});
        r[LEVEL_LSB +: 8] = lvl[7:0];
        rt = clamp({1'b0, w[RATE_LSB +: 15]}, {1'b0, RATE_MIN}, {1'b0, RATE_MAX});
        r[RATE_LSB +: 15] = rt[14:0];
        set_word = r;
    endfunction : set_word

    localparam logic [31:0] SET_RST = {1'b0, RATE_RST, LEVEL_RST, 6'h00, MODE_RST};

    // one step per rate tenths over a full-scale sweep
    step_if st ();
    restrict_stepper #(.STEP_DIV(TENTH_CYCLES / FULL_STEPS)) u_stepper (
        .clk_sys(clk_sys),
        .rst(rst),
        .st(st)
    );

    // register file
    logic [31:0] ctrl_r, ctrl_nxt, set1_r, set1_nxt, set2_r, set2_nxt;
    logic [31:0] out_func_r, out_func_nxt, in_func_r, in_func_nxt;
    // status bits: restriction start, hold start, warning rise
    logic [2:0] status_r, status_nxt, mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    // datapath state
    restrict_state_type rs_r, rs_nxt;
    logic down_r, down_nxt, up_r, up_nxt, hold_r, hold_nxt;
    logic warn_r, warn_nxt, irq_r, irq_nxt;
    logic t1_r, t1_nxt, t2_r, t2_nxt, rel_r, rel_nxt;
    // combinational helpers
    logic req, accept, sel2, phase_ok, over;
    restrict_mode_type mode_sel;
    logic [7:0] lvl_sel;
    logic [31:0] set_sel;
    logic [2:0] events;

    assign req = avs_read | avs_write;
    // a request is served on its second cycle only
    assign accept = req & ~wait_r;

    // function 39 on any input terminal picks set two
    always_comb begin
        sel2 = 1'b0;
        for (int i = 0; i < IN_TERMS; i++) begin
            if (in_terms[i] && in_func_r[i*8 +: 8] == SET_SELECT_FUNC) begin
                sel2 = 1'b1;
            end
        end
    end

    assign set_sel = sel2 ? set2_r : set1_r;
    assign mode_sel = restrict_mode_type'(set_sel[MODE_LSB +: 2]);
    assign lvl_sel = set_sel[LEVEL_LSB +: 8];
    // strictly above; current equal to the level counts as relieved
    assign over = current_pct > lvl_sel;

    // phases in which each mode acts
    always_comb begin
        case (mode_sel)
            MODE_ACC_CONST: phase_ok = ramp_accel | ramp_const;
            MODE_CONST_ONLY: phase_ok = ramp_const;
            MODE_ACC_REGEN: phase_ok = ramp_accel | ramp_const;
            default: phase_ok = 1'b0;
        endcase
    end

    assign st.run = rs_r == R_ACTIVE;
    // rate follows the selected set live; a switch takes hold mid-sweep
    assign st.rate = set_sel[RATE_LSB +: 15];

    // restriction and suppression datapath
    always_comb begin
        rs_nxt = rs_r;
        case (rs_r)
            R_IDLE: if (over && phase_ok) rs_nxt = R_ACTIVE;
            // stay until current drops to the level or the mode is switched off
            R_ACTIVE: if (!over || mode_sel == MODE_OFF) rs_nxt = R_IDLE;
            default: rs_nxt = R_IDLE;
        endcase
        // lower while powering, raise in regen mode
        down_nxt = st.tick & st.run & ~regen;
        up_nxt = st.tick & st.run & regen & (mode_sel == MODE_ACC_REGEN);
        // hold ramp above fixed level; pause only
        hold_nxt = ctrl_r[0] & (current_pct > SUPPRESS_PCT) & (ramp_accel | ramp_decel);
        warn_nxt = thermal_pct > ctrl_r[WARN_LSB +: 8];
        // routed only where the terminal carries it
        t1_nxt = warn_nxt & (out_func_r[7:0] == THM_FUNC);
        t2_nxt = warn_nxt & (out_func_r[15:8] == THM_FUNC);
        rel_nxt = warn_nxt & (out_func_r[23:16] == THM_FUNC);
    end

    // events only feed status; no alarm or trip path
    assign events = {warn_nxt & ~warn_r, hold_nxt & ~hold_r, rs_nxt == R_ACTIVE && rs_r == R_IDLE};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rs_r <= R_IDLE;
            down_r <= 1'b0;
            up_r <= 1'b0;
            hold_r <= 1'b0;
            warn_r <= 1'b0;
            t1_r <= 1'b0;
            t2_r <= 1'b0;
            rel_r <= 1'b0;
        end else begin
            rs_r <= rs_nxt;
            down_r <= down_nxt;
            up_r <= up_nxt;
            hold_r <= hold_nxt;
            warn_r <= warn_nxt;
            t1_r <= t1_nxt;
            t2_r <= t2_nxt;
            rel_r <= rel_nxt;
        end
    end

    // bus slave: one wait cycle, data loaded before release
    always_comb begin
        ctrl_nxt = ctrl_r;
        set1_nxt = set1_r;
        set2_nxt = set2_r;
        out_func_nxt = out_func_r;
        in_func_nxt = in_func_r;
        mask_nxt = mask_r;
        wait_nxt = ~(req & wait_r);
        rdata_nxt = rdata_r;
        // set wins over the read clear
        status_nxt = status_r | events;
        if (req && wait_r && avs_read) begin
            case (avs_address)
                CTRL_OFS: rdata_nxt = ctrl_r;
                SET1_OFS: rdata_nxt = set1_r;
                SET2_OFS: rdata_nxt = set2_r;
                OUT_FUNC_OFS: rdata_nxt = out_func_r;
                STATUS_OFS: rdata_nxt = {29'h0, status_r};
                MASK_OFS: rdata_nxt = {29'h0, mask_r};
                STATE_OFS: rdata_nxt = {26'h0, sel2, warn_r, hold_r, rs_r == R_ACTIVE, up_r, down_r};
                IN_FUNC_OFS: rdata_nxt = in_func_r;
                default: rdata_nxt = '0;
            endcase
        end
        if (accept && avs_read && avs_address == STATUS_OFS) begin
            // clear only what the read reported; a rise since then survives
            status_nxt = (status_r & ~rdata_r[2:0]) | events;
        end
        if (accept && avs_write) begin
            case (avs_address)
                CTRL_OFS: ctrl_nxt = {16'h0, avs_writedata[WARN_LSB +: 8], 7'h0, avs_writedata[0]};
                SET1_OFS: set1_nxt = set_word(avs_writedata);
                SET2_OFS: set2_nxt = set_word(avs_writedata);
                OUT_FUNC_OFS: out_func_nxt = {8'h0, avs_writedata[23:0]};
                MASK_OFS: mask_nxt = avs_writedata[2:0];
                IN_FUNC_OFS: in_func_nxt = avs_writedata;
                default: ;
            endcase
        end
        // from next values, so irq follows status with no extra lag
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r <= {16'h0, WARN_RST, 8'h01};
            set1_r <= SET_RST;
            set2_r <= SET_RST;
            out_func_r <= '0;
            in_func_r <= '0;
            status_r <= '0;
            mask_r <= '0;
            rdata_r <= '0;
            wait_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            set1_r <= set1_nxt;
            set2_r <= set2_nxt;
            out_func_r <= out_func_nxt;
            in_func_r <= in_func_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign freq_down_step = down_r;
    assign freq_up_step = up_r;
    // hold only stretches the ramp, never regulates
    assign ramp_hold = hold_r;
    assign out_term1 = t1_r;
    assign out_term2 = t2_r;
    assign relay_out = rel_r;
    assign irq = irq_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_warn_level: assert property ((thermal_pct > ctrl_r[WARN_LSB +: 8]) |=> warn_r)
        else $error("warning missed above level");
    a_warn_route: assert property (out_term1 |-> warn_r && $past(out_func_r[7:0]) == THM_FUNC)
        else $error("warning on unassigned terminal");
    a_down_step: assert property (freq_down_step |-> $past(rs_r) == R_ACTIVE && !$past(regen))
        else $error("frequency lowered without restriction");
    a_regen_up: assert property (freq_up_step |-> $past(mode_sel) == MODE_ACC_REGEN && $past(regen))
        else $error("speed raised outside regen mode");
    a_set_select: assert property ($rose(rs_r == R_ACTIVE) |-> $past(current_pct) > $past(lvl_sel))
        else $error("restriction started below selected level");
    a_keep_active: assert property ((rs_r == R_ACTIVE && over && mode_sel != MODE_OFF) |=> rs_r == R_ACTIVE)
        else $error("restriction left while overloaded");
    a_const_only: assert property ((rs_r == R_IDLE && mode_sel == MODE_CONST_ONLY && !ramp_const)
        |=> rs_r == R_IDLE)
        else $error("constant-only mode acted off constant speed");
    a_mode_off: assert property ((rs_r == R_IDLE && mode_sel == MODE_OFF) |=> rs_r == R_IDLE)
        else $error("disabled mode started restriction");
    // setting, routing, warning, hold and step checks
    a_level_range: assert property (set1_r[LEVEL_LSB +: 8] >= LEVEL_MIN && set1_r[LEVEL_LSB +: 8] <= LEVEL_MAX)
        else $error("level outside range");
    a_level_set2: assert property (set2_r[LEVEL_LSB +: 8] >= LEVEL_MIN && set2_r[LEVEL_LSB +: 8] <= LEVEL_MAX)
        else $error("second level outside range");
    a_rate_range: assert property (set1_r[RATE_LSB +: 15] >= RATE_MIN && set1_r[RATE_LSB +: 15] <= RATE_MAX)
        else $error("rate outside range");
    a_rate_set2: assert property (set2_r[RATE_LSB +: 15] >= RATE_MIN && set2_r[RATE_LSB +: 15] <= RATE_MAX)
        else $error("second rate outside range");
    a_term2_route: assert property (out_term2 |-> warn_r && $past(out_func_r[15:8]) == THM_FUNC)
        else $error("warning on unassigned second terminal");
    a_relay_route: assert property (relay_out |-> warn_r && $past(out_func_r[23:16]) == THM_FUNC)
        else $error("warning on unassigned relay");
    a_warn_clear: assert property ((thermal_pct <= ctrl_r[WARN_LSB +: 8]) |=> !warn_r)
        else $error("warning held below level");
    a_hold_rise: assert property ((ctrl_r[0] && current_pct > SUPPRESS_PCT && ramp_accel) |=> ramp_hold)
        else $error("ramp not held above suppression level");
    a_hold_release: assert property ((current_pct <= SUPPRESS_PCT) |=> !ramp_hold)
        else $error("ramp held below suppression level");
    a_hold_disabled: assert property (!ctrl_r[0] |=> !ramp_hold)
        else $error("ramp held with suppression off");
    a_hold_phase: assert property (ramp_hold |-> $past(ramp_accel || ramp_decel))
        else $error("ramp held outside a ramp phase");
    a_step_exclusive: assert property (!(freq_down_step && freq_up_step))
        else $error("lower and raise steps together");
    // register bus and interrupt checks
    a_bus_answer: assert property ((req && wait_r) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one wait cycle");
    a_bus_idle: assert property (!req |=> avs_waitrequest)
        else $error("bus answered without a request");
    a_irq_level: assert property (irq == |(status_r & mask_r))
        else $error("interrupt out of step with status");

    c_restrict: cover property ($rose(rs_r == R_ACTIVE) ##[1:1000] freq_down_step);
    c_hold: cover property ($rose(ramp_hold) ##[1:20] !ramp_hold);
    c_warn_out: cover property ($rose(relay_out));
    c_irq: cover property ($rose(irq));
    c_regen_up: cover property (freq_up_step);
endmodule : overload_current_limiter

// ===== src/restrict_stepper.sv
// step pulse generator pacing the restriction frequency change
`timescale 1ns/100ps
module restrict_stepper
    import limiter_pkg::*;
#(
    parameter int STEP_DIV = 2000
) (
    input wire logic clk_sys,
    input wire logic rst,
    step_if.gen st
);
    logic [31:0] pre_r, pre_nxt;
    logic [14:0] sub_r, sub_nxt;
    logic tick_r, tick_nxt;

    // rate counts tenths of a second per full-scale sweep
    always_comb begin
        pre_nxt = pre_r;
        sub_nxt = sub_r;
        tick_nxt = 1'b0;
        if (!st.run) begin
            pre_nxt = '0;
            sub_nxt = '0;
        end else if (pre_r == 32'(STEP_DIV - 1)) begin
            pre_nxt = '0;
            if (sub_r + 15'h0001 >= st.rate) begin
                sub_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                sub_nxt = sub_r + 15'h0001;
            end
        end else begin
            pre_nxt = pre_r + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pre_r <= '0;
            sub_r <= '0;
            tick_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            sub_r <= sub_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign st.tick = tick_r;
endmodule : restrict_stepper

// ===== src/step_if.sv
// link between the limiter control and its step generator
`timescale 1ns/100ps
interface step_if;
    logic run;
    logic [14:0] rate;
    logic tick;
    modport ctl (output run, output rate, input tick);
    modport gen (input run, input rate, output tick);
endinterface : step_if

// ===== test/drive_model.sv
// stand-in for the ramp generator and current measurement
`timescale 1ns/100ps
module drive_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] load_pct,
    input wire logic load_set,
    input wire logic [1:0] phase,
    input wire logic freq_down_step,
    output logic [7:0] current_pct,
    output logic ramp_accel,
    output logic ramp_decel,
    output logic ramp_const
);
    logic [7:0] cur_r;
    logic [7:0] cur_nxt;
    always_comb begin
        cur_nxt = cur_r;
        if (load_set) begin
            cur_nxt = load_pct;
        end else if (freq_down_step && cur_r > 8'h05) begin
            // lower frequency sheds load, so the limiter sees its own effect
            cur_nxt = cur_r - 8'h05;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur_r <= 8'h00;
        end else begin
            cur_r <= cur_nxt;
        end
    end
    assign current_pct = cur_r;
    assign ramp_accel = (phase == 2'h1);
    assign ramp_const = (phase == 2'h2);
    assign ramp_decel = (phase == 2'h3);
endmodule : drive_model

// ===== test/overload_current_limiter_tb.sv
// self-checking bench for the overload current limiter
`timescale 1ns/100ps
module overload_current_limiter_tb;
    import limiter_pkg::*;
    typedef struct {logic wr; logic [4:0] a; logic [31:0] d; logic [31:0] e;} row_type;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] current_pct;
    logic [7:0] thermal_pct = 8'h00;
    logic ramp_accel, ramp_decel, ramp_const;
    logic regen = 1'b0;
    logic [IN_TERMS-1:0] in_terms = '0;
    logic freq_down_step, freq_up_step, ramp_hold, out_term1, out_term2, relay_out, irq;
    logic [7:0] load_pct = 8'h00;
    logic load_set = 1'b0;
    logic [1:0] phase = 2'h0;
    logic [31:0] rd;
    int num_errors = 0;
    int cmp_count = 0;
    int downs = 0;
    int ups = 0;
    int dd, du;
    row_type rows[11] = '{
        '{0, 5'h00, 0, 32'h0000_5001}, '{0, 5'h04, 0, 32'h000a_9601}, '{0, 5'h08, 0, 32'h000a_9601},
        '{0, 5'h0c, 0, 0}, '{0, 5'h14, 0, 0}, '{0, 5'h1c, 0, 0}, '{0, 5'h02, 0, 0},
        '{1, 5'h02, 32'hffff_ffff, 0}, '{1, 5'h10, 32'hffff_ffff, 0},
        '{1, 5'h04, 32'h0000_0a02, 32'h0001_1402}, '{1, 5'h04, 32'h7fff_ff03, 32'h7530_c803}};

    overload_current_limiter #(.TENTH_CYCLES(100), .FULL_STEPS(10)) dut (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .current_pct(current_pct), .thermal_pct(thermal_pct),
        .ramp_accel(ramp_accel), .ramp_decel(ramp_decel), .ramp_const(ramp_const), .regen(regen),
        .in_terms(in_terms), .freq_down_step(freq_down_step), .freq_up_step(freq_up_step),
        .ramp_hold(ramp_hold), .out_term1(out_term1), .out_term2(out_term2), .relay_out(relay_out),
        .irq(irq));
    drive_model model (
        .clk_sys(clk_sys), .rst(rst), .load_pct(load_pct), .load_set(load_set), .phase(phase),
        .freq_down_step(freq_down_step), .current_pct(current_pct), .ramp_accel(ramp_accel),
        .ramp_decel(ramp_decel), .ramp_const(ramp_const));

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (freq_down_step === 1'b1) downs <= downs + 1;
        if (freq_up_step === 1'b1) ups <= ups + 1;
    end

    task complete_run;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    // holds the request until waitrequest is sampled low
    // no wait limit here; the watchdog ends a hung access
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task load(input logic [7:0] pct, input logic [1:0] ph);
        @(posedge clk_sys);
        load_pct <= pct;
        phase <= ph;
        load_set <= 1'b1;
        @(posedge clk_sys);
        load_set <= 1'b0;
    endtask : load

    task span(input int n);
        int d0, u0;
        d0 = downs;
        u0 = ups;
        repeat (n) @(posedge clk_sys);
        dd = downs - d0;
        du = ups - u0;
    endtask : span

    initial begin
        #(50 * 20000);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            chk_word(rd, rows[i].e);
        end
        // ten steps of 5 bring 150 down to the level of 100
        bus(1'b1, 5'h04, 32'h0001_6401);
        load(8'd150, 2'h2);
        span(300);
        chk_word(32'(dd), 32'd10);
        chk_word(32'(du), 32'd0);
        chk_bit(irq, 1'b0);
        bus(1'b1, 5'h14, 32'h0000_0007);
        repeat (2) @(posedge clk_sys);
        chk_bit(irq, 1'b1);
        bus(1'b0, 5'h10, 32'h0);
        chk_word(rd, 32'h0000_0001);
        bus(1'b0, 5'h10, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk_word(rd, 32'h0);
        chk_bit(irq, 1'b0);
        // regeneration mode raises instead of lowering
        bus(1'b1, 5'h04, 32'h0001_6403);
        regen <= 1'b1;
        load(8'd150, 2'h1);
        span(60);
        chk_word(32'(dd), 32'd0);
        chk_bit(du > 0, 1'b1);
        regen <= 1'b0;
        load(8'd0, 2'h0);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 5'h04, (k == 0) ? 32'h0001_6400 : 32'h0001_6402);
            load(8'd150, (k == 1) ? 2'h1 : 2'h2);
            span(60);
            chk_bit(dd > 0, k == 2);
            load(8'd0, 2'h0);
        end
        // second set picked by input function 0x27
        bus(1'b1, 5'h04, 32'h0001_6400);
        bus(1'b1, 5'h08, 32'h0001_6401);
        bus(1'b1, 5'h1c, 32'h0000_0027);
        in_terms <= 4'h1;
        load(8'd150, 2'h2);
        span(60);
        chk_bit(dd > 0, 1'b1);
        bus(1'b0, 5'h18, 32'h0);
        chk_bit(rd[5], 1'b1);
        load(8'd0, 2'h0);
        in_terms <= 4'h0;
        load(8'd150, 2'h2);
        span(60);
        chk_word(32'(dd), 32'd0);
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, 5'h00, (k == 4) ? 32'h0000_5000 : 32'h0000_5001);
            load((k == 1) ? 8'd180 : 8'd181, (k == 2) ? 2'h3 : ((k == 3) ? 2'h2 : 2'h1));
            repeat (3) @(posedge clk_sys);
            chk_bit(ramp_hold, k == 0 || k == 2);
        end
        bus(1'b1, 5'h0c, 32'h000d_000d);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 5'h00, (k < 2) ? 32'h0000_5001 : 32'h0000_6001);
            thermal_pct <= (k == 0) ? 8'd81 : ((k == 1) ? 8'd79 : ((k == 2) ? 8'd90 : 8'd97));
            repeat (3) @(posedge clk_sys);
            chk_bit(out_term1, k == 0 || k == 3);
            chk_bit(relay_out, k == 0 || k == 3);
            chk_bit(out_term2, 1'b0);
        end
        // warning still on; move it from terminal one to terminal two
        bus(1'b1, 5'h0c, 32'h0000_0d00);
        repeat (2) @(posedge clk_sys);
        chk_bit(out_term2, 1'b1);
        chk_bit(out_term1, 1'b0);
        // reset in mid-run restores defaults
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        chk_bit(avs_waitrequest, 1'b1);
        chk_bit(relay_out, 1'b0);
        bus(1'b0, 5'h00, 32'h0);
        chk_word(rd, 32'h0000_5001);
        complete_run();
    end
endmodule : overload_current_limiter_tb
